// ===== src/uft_pkg.sv
/*
  Constants, types and helper functions for the serial transmit block.
  Assumes a single 250 MHz clock and a plain strobe register port.
*/
package uft_pkg;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [3:0] ADDR_HOLD = 4'h0;
  localparam logic [3:0] ADDR_DIV_LO = 4'h1;
  localparam logic [3:0] ADDR_DIV_HI = 4'h2;
  localparam logic [3:0] ADDR_DIV_FR = 4'h3;
  localparam logic [3:0] ADDR_FIFO_CTL = 4'h4;
  localparam logic [3:0] ADDR_LINE_CTL = 4'h5;
  localparam logic [3:0] ADDR_MODEM = 4'h6;
  localparam logic [3:0] ADDR_IEN = 4'h7;
  localparam logic [3:0] ADDR_ISTS = 4'h8;
  localparam logic [3:0] ADDR_ICLR = 4'h9;
  localparam logic [3:0] ADDR_LSTS = 4'hA;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [7:0] DIV_LO_RST = 8'h01;
  localparam logic [7:0] DIV_HI_RST = 8'h00;
  localparam logic [5:0] DIV_FR_RST = 6'h00;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int FCR_EN_BIT = 0;
  localparam int FCR_TRIG_LSB = 4;
  localparam int LCR_STOP_BIT = 2;
  localparam int LCR_PEN_BIT = 3;
  localparam int LCR_EVEN_BIT = 4;
  localparam int DFR_SEL_LSB = 4;
  localparam int MCR_PRESC_BIT = 7;
  localparam int LSR_THRE_BIT = 5;
  localparam int LSR_TEMT_BIT = 6;
  localparam int IST_TXE_BIT = 1;
  localparam int IST_TEMT_BIT = 2;

  // ----------------------------------------
  // Sizes and counts
  // ----------------------------------------
  localparam int FIFO_DEPTH = 32;
  localparam logic [5:0] FIFO_CAP = 6'h20;
  localparam logic [5:0] HOLD_CAP = 6'h01;
  localparam logic [1:0] PRESC_LAST = 2'h3;
  localparam logic [1:0] SEL_16X = 2'h0;
  localparam logic [1:0] SEL_8X = 2'h1;
  localparam logic [1:0] SEL_4X = 2'h2;
  localparam logic [3:0] LAST_16X = 4'hF;
  localparam logic [3:0] LAST_8X = 4'h7;
  localparam logic [3:0] LAST_4X = 4'h3;

  // Last sampling period index of one bit
  function automatic logic [3:0] os_last(input logic [1:0] sel);
    case (sel)
      SEL_8X: os_last = LAST_8X;
      SEL_4X: os_last = LAST_4X;
      default: os_last = LAST_16X;
    endcase
  endfunction

  // Transmit trigger level in bytes
  function automatic logic [5:0] trig_level(input logic [1:0] sel);
    case (sel)
      2'h0: trig_level = 6'h08;
      2'h1: trig_level = 6'h10;
      2'h2: trig_level = 6'h18;
      default: trig_level = 6'h1C;
    endcase
  endfunction

  typedef enum logic [2:0] {
    ST_IDLE, ST_START, ST_DATA, ST_PARITY, ST_STOP
  } uft_tx_st_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } uft_bus_req_t;

  typedef struct packed {
    logic [15:0] div_int;
    logic [3:0] div_frac;
    logic presc4;
  } uft_baud_cfg_t;

endpackage

// ===== src/uft_baud_gen.sv
/*
  Prescaler and fractional divider making the sampling clock tick.
  Assumes the configuration is static while characters are sent.
*/
`timescale 1ns/1ns
module uft_baud_gen (
  input wire logic mclk,
  input wire logic rst_n,
  input wire uft_pkg::uft_baud_cfg_t cfg,
  output logic tick
);
  import uft_pkg::*;

  typedef struct packed {
    logic [1:0] pre;
    logic [16:0] cnt;
    logic [3:0] acc;
    logic stretch;
    logic tick;
  } uft_baud_st_t;

  uft_baud_st_t r, n;
  logic pre_tick;
  logic [16:0] base;
  logic [16:0] last;
  logic [4:0] sum;

  // ----------------------------------------
  // Divider
  // ----------------------------------------
  always_comb begin
    n = r;
    n.tick = 1'b0;
    // [R15] Divide by one or four
    pre_tick = !cfg.presc4 || (r.pre == PRESC_LAST);
    n.pre = pre_tick ? 2'h0 : r.pre + 2'h1;
    // [R13] Integer part of divisor
    base = (cfg.div_int == 16'h0000) ? 17'h00000 :
           {1'b0, cfg.div_int} - 17'h00001;
    last = base + {16'h0000, r.stretch};
    // [R18] Carry of sixteenths stretches a period
    sum = {1'b0, r.acc} + {1'b0, cfg.div_frac};
    if (pre_tick) begin
      if (r.cnt >= last) begin
        n.cnt = 17'h00000;
        n.tick = 1'b1;
        n.acc = sum[3:0];
        n.stretch = sum[4];
      end else begin
        n.cnt = r.cnt + 17'h00001;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign tick = r.tick;

endmodule

// ===== src/uft_tx.sv
/*
  Transmit path of one serial channel: registers, 32-byte queue,
  shifter, status and interrupt.
  Assumes a one-clock register port; the host honours queue space.
*/
`timescale 1ns/1ns
// Notes on behaviour
// [R1] Each bit lasts 16, 8 or 4 sampling ticks per select field.
// [R2] Frame is start, data bits, optional parity, then stop bits.
// [R3] Data leave least significant bit first.
// [R4] With queue enabled, holding writes enter a 32-byte queue.
// [R5] Each holding write advances the write pointer by one. Code: a write to a full queue is dropped and leaves the pointer unchanged.
// [R6] Queue off: holding-empty flag sets when byte moves to shifter.
// [R7] Queue off: holding-empty raises transmit interrupt if enabled.
// [R8] Queue off: transmitter-empty flag sets when shifter is idle.
// [R9] Queue on: holding-empty flag set whenever queue is empty.
// [R10] Queue on: interrupt when fill drops below trigger level.
// [R11] Queue on: transmitter-empty needs queue and shifter empty.
// [R12] Host loads at most 32 bytes before waiting for space.
// [R13] Divisor is integer bytes plus four bits of sixteenths.
// [R14] Select code 00 is 16X, 01 is 8X, 10 is 4X.
// [R15] Prescaler divides input clock by 1 or 4 from modem bit 7.
// [R16] After reset the divisor is one.
// [R17] Line idles high; start bit is low.
// [R18] Fraction is made by stretching some sampling periods.
module uft_tx (
  input wire logic mclk,
  input wire logic rst_n,
  input wire uft_pkg::uft_bus_req_t req,
  output logic [7:0] rdata,
  output logic txd,
  output logic irq
);
  import uft_pkg::*;

  typedef struct packed {
    logic [7:0] div_lo;
    logic [7:0] div_hi;
    logic [5:0] div_fr;
    logic [5:0] fifo_ctl;
    logic [4:0] line_ctl;
    logic [7:0] modem;
    logic [2:0] ien;
    logic [2:0] ists;
    logic [4:0] wptr;
    logic [4:0] rptr;
    logic [5:0] count;
    uft_tx_st_t st;
    logic [7:0] sh;
    logic [3:0] os;
    logic [2:0] bitn;
    logic par;
    logic txe_q;
    logic temt_q;
    logic [7:0] rdata;
    logic txd;
    logic irq;
  } uft_tx_state_t;

  uft_tx_state_t r, n;
  logic [7:0] mem [FIFO_DEPTH];
  logic tick;
  uft_baud_cfg_t bcfg;
  logic fifo_on, accept, pop, flush, bit_end;
  logic thre, temt, txe_cond;
  logic [5:0] cap;
  logic [3:0] last;
  logic [2:0] nbits_last;
  logic [2:0] set_b;

  // ----------------------------------------
  // Sampling clock
  // ----------------------------------------
  assign bcfg.div_int = {r.div_hi, r.div_lo};
  assign bcfg.div_frac = r.div_fr[3:0];
  assign bcfg.presc4 = r.modem[MCR_PRESC_BIT];

  uft_baud_gen u_baud (
    .mclk(mclk),
    .rst_n(rst_n),
    .cfg(bcfg),
    .tick(tick)
  );

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    n = r;
    n.rdata = 8'h00;
    fifo_on = r.fifo_ctl[FCR_EN_BIT];
    // [R4] Queue of 32 or single holding byte
    cap = fifo_on ? FIFO_CAP : HOLD_CAP;
    // [R1] [R14] Bit length from select field
    last = os_last(r.div_fr[DFR_SEL_LSB +: 2]);
    nbits_last = {1'b1, r.line_ctl[1:0]};
    bit_end = tick && (r.os == last);
    // [R12] Writes to a full queue are dropped
    accept = req.wr && (req.addr == ADDR_HOLD) && (r.count < cap);
    flush = req.wr && (req.addr == ADDR_FIFO_CTL) &&
            (req.wdata[FCR_EN_BIT] != fifo_on);
    pop = 1'b0;

    // Register writes
    if (req.wr) begin
      case (req.addr)
        ADDR_DIV_LO: n.div_lo = req.wdata;
        ADDR_DIV_HI: n.div_hi = req.wdata;
        ADDR_DIV_FR: n.div_fr = req.wdata[5:0];
        ADDR_FIFO_CTL: n.fifo_ctl = req.wdata[5:0];
        ADDR_LINE_CTL: n.line_ctl = req.wdata[4:0];
        ADDR_MODEM: n.modem = req.wdata;
        ADDR_IEN: n.ien = req.wdata[2:0];
        default: ;
      endcase
    end

    // [R2] Frame sequencer
    case (r.st)
      ST_IDLE: begin
        if (r.count != 6'h00) begin
          pop = 1'b1;
          n.sh = mem[r.rptr];
          n.os = 4'h0;
          n.bitn = 3'h0;
          n.par = 1'b0;
          n.st = ST_START;
        end
      end
      ST_START: begin
        if (tick) n.os = r.os + 4'h1;
        if (bit_end) begin
          n.os = 4'h0;
          n.st = ST_DATA;
        end
      end
      ST_DATA: begin
        if (tick) n.os = r.os + 4'h1;
        if (bit_end) begin
          // [R3] Shift right, bit 0 first
          n.os = 4'h0;
          n.par = r.par ^ r.sh[0];
          n.sh = {1'b0, r.sh[7:1]};
          n.bitn = r.bitn + 3'h1;
          if (r.bitn == nbits_last) begin
            n.bitn = 3'h0;
            n.st = r.line_ctl[LCR_PEN_BIT] ? ST_PARITY : ST_STOP;
          end
        end
      end
      ST_PARITY: begin
        if (tick) n.os = r.os + 4'h1;
        if (bit_end) begin
          n.os = 4'h0;
          n.st = ST_STOP;
        end
      end
      ST_STOP: begin
        if (tick) n.os = r.os + 4'h1;
        if (bit_end) begin
          n.os = 4'h0;
          n.bitn = r.bitn + 3'h1;
          if (!r.line_ctl[LCR_STOP_BIT] || r.bitn != 3'h0) begin
            n.bitn = 3'h0;
            n.st = ST_IDLE;
          end
        end
      end
      default: n.st = ST_IDLE;
    endcase

    // [R5] Pointer bump on every accepted write
    if (accept) n.wptr = r.wptr + 5'h01;
    if (pop) n.rptr = r.rptr + 5'h01;
    n.count = r.count + {5'h00, accept} - {5'h00, pop};
    if (flush) begin
      n.wptr = 5'h00;
      n.rptr = 5'h00;
      n.count = 6'h00;
    end

    // [R17] Idle and stop high, start low
    case (n.st)
      ST_START: n.txd = 1'b0;
      ST_DATA: n.txd = n.sh[0];
      ST_PARITY: n.txd = r.line_ctl[LCR_EVEN_BIT] ? n.par : ~n.par;
      default: n.txd = 1'b1;
    endcase

    // [R6] [R9] Holding empty when nothing queued
    thre = (r.count == 6'h00);
    // [R8] [R11] Shifter and queue both empty
    temt = thre && (r.st == ST_IDLE);
    // [R10] Below trigger level with queue on
    txe_cond = fifo_on ? (r.count < trig_level(r.fifo_ctl[FCR_TRIG_LSB +: 2]))
                       : thre;
    n.txe_q = txe_cond;
    n.temt_q = temt;
    set_b = 3'h0;
    set_b[IST_TXE_BIT] = txe_cond && !r.txe_q;
    set_b[IST_TEMT_BIT] = temt && !r.temt_q;
    n.ists = r.ists | set_b;
    if (req.wr && req.addr == ADDR_ICLR) begin
      n.ists = (r.ists & ~req.wdata[2:0]) | set_b;
    end
    // [R7] Interrupt gated by enable bits
    n.irq = |(n.ists & n.ien);

    // Register reads
    if (req.rd) begin
      case (req.addr)
        ADDR_DIV_LO: n.rdata = r.div_lo;
        ADDR_DIV_HI: n.rdata = r.div_hi;
        ADDR_DIV_FR: n.rdata = {2'h0, r.div_fr};
        ADDR_FIFO_CTL: n.rdata = {2'h0, r.fifo_ctl};
        ADDR_LINE_CTL: n.rdata = {3'h0, r.line_ctl};
        ADDR_MODEM: n.rdata = r.modem;
        ADDR_IEN: n.rdata = {5'h00, r.ien};
        ADDR_ISTS: n.rdata = {5'h00, r.ists};
        ADDR_LSTS: begin
          n.rdata[LSR_THRE_BIT] = thre;
          n.rdata[LSR_TEMT_BIT] = temt;
        end
        default: n.rdata = 8'h00;
      endcase
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      r <= '0;
      // [R16] Divisor of one
      r.div_lo <= DIV_LO_RST;
      r.div_hi <= DIV_HI_RST;
      r.div_fr <= DIV_FR_RST;
      r.st <= ST_IDLE;
      r.txd <= 1'b1;
      r.txe_q <= 1'b1;
      r.temt_q <= 1'b1;
    end else begin
      r <= n;
    end
  end

  always_ff @(posedge mclk) begin
    if (accept) mem[r.wptr] <= req.wdata;
  end

  assign rdata = r.rdata;
  assign txd = r.txd;
  assign irq = r.irq;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_idle_high;
    @(posedge mclk) disable iff (!rst_n)
    (r.st == ST_IDLE) |-> txd;
  endproperty
  a_idle_high: assert property (p_idle_high) // [R17]
    else $error("line not high while idle");

  property p_start_low;
    @(posedge mclk) disable iff (!rst_n)
    (r.st == ST_IDLE && r.count != 6'h00) |=> !txd && r.st == ST_START;
  endproperty
  a_start_low: assert property (p_start_low) // [R2]
    else $error("start bit not driven low");

  property p_lsb_next;
    @(posedge mclk) disable iff (!rst_n)
    (r.st == ST_DATA && bit_end && r.bitn != nbits_last)
      |=> txd == $past(r.sh[1]);
  endproperty
  a_lsb_next: assert property (p_lsb_next) // [R3]
    else $error("data bit order wrong");

  property p_bit_len;
    @(posedge mclk) disable iff (!rst_n)
    (r.st != ST_IDLE) |-> r.os <= last;
  endproperty
  a_bit_len: assert property (p_bit_len) // [R1]
    else $error("bit period overran select length");

  property p_wptr_step;
    @(posedge mclk) disable iff (!rst_n)
    (accept && !flush) |=> r.wptr == $past(r.wptr) + 5'h01;
  endproperty
  a_wptr_step: assert property (p_wptr_step) // [R5]
    else $error("write pointer did not advance");

  property p_cap;
    @(posedge mclk) disable iff (!rst_n)
    r.count <= FIFO_CAP && (r.fifo_ctl[FCR_EN_BIT] || r.count <= HOLD_CAP);
  endproperty
  a_cap: assert property (p_cap) // [R4]
    else $error("queue fill beyond capacity");

  property p_temt;
    @(posedge mclk) disable iff (!rst_n)
    (req.rd && req.addr == ADDR_LSTS && r.st != ST_IDLE)
      |=> !rdata[LSR_TEMT_BIT];
  endproperty
  a_temt: assert property (p_temt) // [R11]
    else $error("transmitter empty shown while shifting");

  property p_irq_gate;
    @(posedge mclk) disable iff (!rst_n)
    irq |-> |(r.ists & r.ien);
  endproperty
  a_irq_gate: assert property (p_irq_gate) // [R7]
    else $error("interrupt without enabled status");

  property p_set_wins;
    @(posedge mclk) disable iff (!rst_n)
    (set_b[IST_TXE_BIT]) |=> r.ists[IST_TXE_BIT];
  endproperty
  a_set_wins: assert property (p_set_wins) // [R10]
    else $error("transmit empty event lost");

endmodule

// ===== bench/uft_rx_model.sv
/*
  Behavioural remote serial receiver watching the transmit line.
  Assumes a fixed bit time in clocks and frame format from the bench.
*/
`timescale 1ns/1ns
module uft_rx_model #(
  parameter int BIT_CYC = 16
) (
  input wire logic mclk,
  input wire logic txd,
  input wire logic [3:0] nbits,
  input wire logic par_en,
  output logic [7:0] rx_data,
  output logic rx_par,
  output logic rx_stop,
  output int rx_cnt
);
  logic [7:0] d;
  int i;

  // ----------------------------------------
  // Mid-bit sampling of each frame
  // ----------------------------------------
  initial begin
    rx_cnt = 0;
    rx_data = 8'h00;
    rx_par = 1'b0;
    rx_stop = 1'b0;
    d = 8'h00;
    forever begin
      @(posedge mclk);
      if (txd === 1'b0) begin
        repeat (BIT_CYC / 2) @(posedge mclk);
        if (txd === 1'b0) begin
          d = 8'h00;
          for (i = 0; i < int'(nbits); i++) begin
            repeat (BIT_CYC) @(posedge mclk);
            d[i] = txd;
          end
          if (par_en) begin
            repeat (BIT_CYC) @(posedge mclk);
            rx_par = txd;
          end
          repeat (BIT_CYC) @(posedge mclk);
          rx_stop = txd;
          rx_data = d;
          rx_cnt++;
        end
      end
    end
  end
endmodule

// ===== bench/testbench.sv
/*
  Self-checking bench for the serial transmit block.
  Assumes the register map of the package and a receiver model.
*/
`timescale 1ns/1ns
module testbench;
  import uft_pkg::*;
  logic mclk;
  logic rst_n;
  uft_bus_req_t req;
  logic [7:0] rdata;
  logic txd;
  logic irq;
  logic [3:0] nbits;
  logic par_en;
  logic [7:0] rx_data;
  logic rx_par;
  logic rx_stop;
  int rx_cnt;
  int error_cnt;
  int n_compared;
  int base;
  int len;
  int k;
  int irq_at;
  logic [7:0] v;
  logic [7:0] fl [4] = '{8'h1B, 8'h0B, 8'h06, 8'h00};
  logic [7:0] fd [4] = '{8'hA5, 8'hA5, 8'hC3, 8'hFA};
  logic [7:0] fe [4] = '{8'hA5, 8'hA5, 8'h43, 8'h1A};
  logic [3:0] nb [4] = '{4'h8, 4'h8, 4'h7, 4'h5};
  logic fp [4] = '{1'b0, 1'b1, 1'b0, 1'b0};

  uft_tx u_uft_tx (.mclk(mclk), .rst_n(rst_n), .req(req), .rdata(rdata),
    .txd(txd), .irq(irq));
  uft_rx_model u_uft_rx_model (.mclk(mclk), .txd(txd), .nbits(nbits),
    .par_en(par_en), .rx_data(rx_data), .rx_par(rx_par),
    .rx_stop(rx_stop), .rx_cnt(rx_cnt));

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  always @(posedge irq) irq_at = rx_cnt;

  // ----------------------------------------
  // Report and compare tasks
  // ----------------------------------------
  task automatic close_out();
    if (error_cnt == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic fail(input string msg);
    error_cnt++;
    $display("CHECK FAILED %0t %s", $time, msg);
  endtask

  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp,
    input logic [7:0] mask, input string msg);
    n_compared++;
    if ((got & mask) !== (exp & mask)) fail(msg);
  endtask

  task automatic cmp_rng(input int got, input int lo, input int hi,
    input string msg);
    n_compared++;
    if (got < lo || got > hi) fail(msg);
  endtask

  // ----------------------------------------
  // Register port and waits
  // ----------------------------------------
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    req.addr <= a;
    req.wdata <= d;
    req.wr <= 1'b1;
    @(posedge mclk);
    req.wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge mclk);
    req.addr <= a;
    req.rd <= 1'b1;
    @(posedge mclk);
    req.rd <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic wait_rx(input int n);
    int i;
    for (i = 0; i < 20000 && rx_cnt < n; i++) @(posedge mclk);
    if (rx_cnt < n) begin
      fail("frame missing");
      close_out();
    end
  endtask

  task automatic wait_idle();
    int i;
    logic [7:0] s;
    s = 8'h00;
    for (i = 0; i < 3000 && s[LSR_TEMT_BIT] !== 1'b1; i++) rd(ADDR_LSTS, s);
    n_compared++;
    if (s[LSR_TEMT_BIT] !== 1'b1) begin
      fail("line never idle");
      close_out();
    end
  endtask

  task automatic measure(input logic [7:0] fr, input logic [7:0] md,
    input logic [7:0] lo8, input int lo, input int hi);
    int i;
    wr(ADDR_DIV_FR, fr);
    wr(ADDR_MODEM, md);
    wr(ADDR_DIV_LO, lo8);
    cmp8({7'h00, txd}, 8'h01, 8'h01, "line not idle high");
    wr(ADDR_HOLD, 8'hF0);
    len = 0;
    for (i = 0; i < 50 && txd !== 1'b0; i++) @(posedge mclk);
    while (len < 400 && txd === 1'b0) begin
      @(posedge mclk);
      len++;
    end
    cmp_rng(len, lo, hi, "low run length");
    wait_idle();
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    rst_n = 1'b0;
    req = '0;
    nbits = 4'h8;
    par_en = 1'b0;
    error_cnt = 0;
    n_compared = 0;
    irq_at = 0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    cmp8({7'h00, txd}, 8'h01, 8'h01, "idle after reset");
    rd(ADDR_DIV_LO, v);
    cmp8(v, DIV_LO_RST, 8'hFF, "divisor low reset");
    rd(ADDR_DIV_HI, v);
    cmp8(v, 8'h00, 8'hFF, "divisor high reset");
    rd(ADDR_DIV_FR, v);
    cmp8(v, 8'h00, 8'h3F, "divisor fraction reset");
    rd(4'hF, v);
    cmp8(v, 8'h00, 8'hFF, "unmapped read");
    rd(ADDR_LSTS, v);
    cmp8(v, 8'h60, 8'h60, "status after reset");
    for (k = 0; k < 4; k++) begin
      wr(ADDR_LINE_CTL, fl[k]);
      nbits <= nb[k];
      par_en <= fl[k][LCR_PEN_BIT];
      base = rx_cnt;
      wr(ADDR_HOLD, fd[k]);
      wait_rx(base + 1);
      cmp8(rx_data, fe[k], 8'hFF, "received data");
      cmp8({7'h00, rx_par}, {7'h00, fp[k]}, 8'(fl[k][3]), "parity");
      cmp8({7'h00, rx_stop}, 8'h01, 8'h01, "stop bit");
      wait_idle();
    end
    wr(ADDR_LINE_CTL, 8'h03);
    nbits <= 4'h8;
    par_en <= 1'b0;
    wr(ADDR_IEN, 8'h02);
    wr(ADDR_ICLR, 8'hFF);
    base = rx_cnt;
    wr(ADDR_HOLD, 8'h3C);
    rd(ADDR_LSTS, v);
    cmp8(v, 8'h20, 8'h60, "holding empty, shifter busy");
    repeat (3) @(posedge mclk);
    cmp8({7'h00, irq}, 8'h01, 8'h01, "empty interrupt");
    wr(ADDR_IEN, 8'h00);
    repeat (2) @(posedge mclk);
    cmp8({7'h00, irq}, 8'h00, 8'h01, "masked interrupt");
    rd(ADDR_ISTS, v);
    cmp8(v, 8'h02, 8'h02, "sticky status");
    wr(ADDR_IEN, 8'h02);
    repeat (2) @(posedge mclk);
    cmp8({7'h00, irq}, 8'h01, 8'h01, "unmasked interrupt");
    wr(ADDR_ICLR, 8'h06);
    repeat (2) @(posedge mclk);
    cmp8({7'h00, irq}, 8'h00, 8'h01, "cleared interrupt");
    wait_rx(base + 1);
    cmp8(rx_data, 8'h3C, 8'hFF, "single byte");
    wait_idle();
    wr(ADDR_FIFO_CTL, 8'h01);
    base = rx_cnt;
    for (k = 0; k < 35; k++) wr(ADDR_HOLD, 8'(k) + 8'h40);
    rd(ADDR_LSTS, v);
    cmp8(v, 8'h00, 8'h60, "queue holds data");
    wr(ADDR_ICLR, 8'hFF);
    for (k = 0; k < 33; k++) begin
      wait_rx(base + k + 1);
      cmp8(rx_data, 8'(k) + 8'h40, 8'hFF, "queue order");
      if (k == 9) cmp8({7'h00, irq}, 8'h00, 8'h01, "above trigger");
      if (k == 31) begin
        repeat (20) @(posedge mclk);
        rd(ADDR_LSTS, v);
        cmp8(v, 8'h20, 8'h60, "queue empty, shifter busy");
      end
    end
    cmp_rng(irq_at - base, 24, 25, "trigger crossing");
    repeat (400) @(posedge mclk);
    cmp_rng(rx_cnt - base, 33, 33, "full queue drops");
    wait_idle();
    // ----------------------------------------
    // Trigger levels 16, 24 and 28
    // ----------------------------------------
    base = rx_cnt;
    for (k = 0; k < 27; k++) wr(ADDR_HOLD, 8'(k));
    wr(ADDR_ICLR, 8'hFF);
    wr(ADDR_FIFO_CTL, 8'h11);
    repeat (2) @(posedge mclk);
    cmp8({7'h00, irq}, 8'h00, 8'h01, "fill above level 16");
    wr(ADDR_FIFO_CTL, 8'h21);
    repeat (2) @(posedge mclk);
    cmp8({7'h00, irq}, 8'h00, 8'h01, "fill above level 24");
    wr(ADDR_FIFO_CTL, 8'h31);
    repeat (2) @(posedge mclk);
    cmp8({7'h00, irq}, 8'h01, 8'h01, "fill below level 28");
    wait_rx(base + 27);
    cmp8(rx_data, 8'h1A, 8'hFF, "last byte kept");
    wait_idle();
    measure(8'h00, 8'h00, 8'h01, 79, 80);
    measure(8'h10, 8'h00, 8'h01, 39, 40);
    measure(8'h20, 8'h00, 8'h01, 19, 20);
    measure(8'h30, 8'h00, 8'h01, 79, 80);
    measure(8'h20, 8'h80, 8'h02, 151, 160);
    measure(8'h10, 8'h00, 8'h03, 116, 120);
    measure(8'h08, 8'h00, 8'h01, 117, 121);
    close_out();
  end
endmodule
